// ==== rtl/acd_spi_ctrl.sv ====
// actuator serial control, diagnostics and protection logic
// Behaviour
// - clock idles low; sample data on rising edges, change output on falling
// - both words travel least significant bit first
// - serial output floats while chip select is high
// - fault bit shows on output as soon as chip select falls
// - frame commits only after exactly 24 rising clock edges
// - shifted word goes to input register after chip select rises
// - first rising edge loads status; each later falling edge shifts a bit
// - first received bit picks input register and returned status
// - bits 1 to 17 govern their driver channels
// - bit 23 of register zero: zero is standby, one is active
// - bit 22 of an accepted frame clears both status registers
// - bits 18 and 19 steer the current monitor multiplexer
// - warning sets its flag; shutdown sets its flag and stops outputs
// - temperature flags latch; a clear holds only once indication is gone
// - open-load flag after 1 ms unbroken low current on an enabled output
// - over-current held 32 us sets flag and switches that driver off
// - without recovery the driver stays off until the flag is cleared
// - with recovery the driver restarts after a duty-derived off time
// - with gating enabled, drive is gate input AND control bit
// - output seven gates from the monitor pin, the rest from gate one
// - opposite switch of a half bridge waits the cross-current delay
// - status bit zero summarises bits 1 to 22 of both registers
// - standby clears latched data and switches every output off
// - reset switches outputs off and clears both status registers
// - with supply recovery disabled, supply trips hold until cleared
`include "acd_defines.svh"
`default_nettype none

module acd_fifo #(
  parameter int W = `ACD_FRAME_BITS,
  parameter int D = `ACD_FIFO_DEPTH
) (
  input  wire logic         clk,
  input  wire logic         rstn,
  input  wire logic         inValid,
  output logic              inReady,
  input  wire logic [W-1:0] inData,
  output logic              outValid,
  input  wire logic         outReady,
  output logic [W-1:0]      outData
);
  localparam int AW = $clog2(D);
  logic [W-1:0]  mem [D];
  logic [AW-1:0] wrPtr;
  logic [AW-1:0] rdPtr;
  logic [AW:0]   fill;
  logic          push;
  logic          pop;

  // pointers wrap on their own, so depth must be a power of two
  assign push     = inValid && inReady;
  assign pop      = outValid && outReady;
  assign inReady  = fill != (AW+1)'(D);
  assign outValid = fill != '0;
  assign outData  = mem[rdPtr];

  // storage needs no reset; the fill count guards every read
  always_ff @(posedge clk) begin
    if (push) begin
      mem[wrPtr] <= inData;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      wrPtr <= '0;
      rdPtr <= '0;
      fill  <= '0;
    end else begin
      if (push) begin
        wrPtr <= wrPtr + 1'h1;
      end
      if (pop) begin
        rdPtr <= rdPtr + 1'h1;
      end
      fill <= fill + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule // acd_fifo

module acd_spi_ctrl #(
  parameter int OL_FILT_CYC = `ACD_OL_FILT_CYC,
  parameter int REC_OFF_LO  = `ACD_REC_OFF(`ACD_DUTY_LO),
  parameter int REC_OFF_HI  = `ACD_REC_OFF(`ACD_DUTY_HI)
) (
  input  wire logic              clk,
  input  wire logic              rstn,
  input  wire logic              spiClk,
  input  wire logic              chipSelectLow,
  input  wire logic              serialIn,
  output logic                   serialOut,
  output logic                   serialOutEn,
  input  wire logic              pulseGateInputOne,
  input  wire logic              monitorOrPulseGatePin,
  input  wire acd_pkg::acd_diag_s diagInd,
  input  wire logic [17:1]       overCurInd,
  input  wire logic [17:1]       lowCurInd,
  output logic [17:1]            drvOn,
  output logic                   chargePumpOn,
  output logic [1:0]             monitorSel,
  output logic                   frameLost
);
  import acd_pkg::*;

  acd_pins_s              pinA;
  acd_pins_s              pin;
  logic                   sclkD;
  logic                   csnD;
  logic                   sclkRise;
  logic                   sclkFall;
  logic                   csnRise;
  logic [`ACD_CNT_W-1:0]  bitCnt;
  acd_word_t              inShift;
  acd_word_t              outShift;
  logic                   started;
  logic                   commit;
  logic                   fifoInRdy;
  logic                   fifoOutValid;
  logic                   apply;
  acd_word_t              fifoData;
  acd_ctl0_s              reg0;
  acd_ctl1_s              reg1;
  acd_ctl0_s              w0;
  logic [`ACD_WAKE_W-1:0] wakeCnt;
  logic                   stbyClr;
  logic                   clrAll;
  acd_diag_s              flg;
  logic                   supOff;
  logic                   globalOff;
  logic                   notReady;
  logic                   fault;
  logic [17:1]            ocFlag;
  logic [17:1]            olFlag;
  logic [17:1]            next_drv;
  logic [17:1]            dem;
  logic [`ACD_NOUT:0]     pwmV;
  logic [`ACD_NOUT:0]     recV;
  logic [`ACD_X_W-1:0]    xCnt [1:`ACD_NHB];
  acd_word_t              stat0;
  acd_word_t              stat1;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);

  // every pin crosses two flops before anything looks at it
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      // chip select idles high, so reset shows no false frame start
      pinA     <= '0;
      pin      <= '0;
      pinA.chip_select_low <= 1'h1;
      pin.chip_select_low  <= 1'h1;
    end else begin
      pinA <= {spiClk, chipSelectLow, serialIn, pulseGateInputOne,
               monitorOrPulseGatePin, diagInd, overCurInd, lowCurInd};
      pin  <= pinA;
    end
  end

  // edge finders on the synchronised link signals
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      sclkD <= 1'h0;
      csnD  <= 1'h1;
    end else begin
      sclkD <= pin.sclk;
      csnD  <= pin.chip_select_low;
    end
  end
  assign sclkRise = pin.sclk && !sclkD && !pin.chip_select_low;
  assign sclkFall = !pin.sclk && sclkD && !pin.chip_select_low;
  assign csnRise  = pin.chip_select_low && !csnD;

  // bit count saturates one past a frame so long frames stay invalid
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      bitCnt <= '0;
    end else if (pin.chip_select_low) begin
      bitCnt <= '0;
    end else if (sclkRise && bitCnt != `ACD_CNT_W'(`ACD_FRAME_BITS + 1)) begin
      bitCnt <= bitCnt + 1'h1;
    end
  end

  // first bit received ends up at position zero
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      inShift <= '0;
    end else if (sclkRise) begin
      inShift <= {pin.sdi, inShift[`ACD_FRAME_BITS-1:1]};
    end
  end
  assign commit = csnRise && bitCnt == `ACD_CNT_W'(`ACD_FRAME_BITS);

  // status words; bit zero is the summary fault in both
  assign notReady = wakeCnt != '0;
  assign fault    = |{flg, notReady, ocFlag, olFlag};
  assign stat0    = {1'h1, flg.ov, flg.uv, flg.thermal_shutdown_flag, flg.tw, notReady,
                     ocFlag, fault};
  assign stat1    = {1'h1, 5'h00, olFlag, fault};

  // out shifter loads on the frame's first rising edge
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      started  <= 1'h0;
      outShift <= '0;
    end else if (pin.chip_select_low) begin
      started <= 1'h0;
    end else if (sclkRise && !started) begin
      started  <= 1'h1;
      outShift <= pin.sdi ? stat1 : stat0;
    end else if (sclkFall && started) begin
      outShift <= {1'h0, outShift[`ACD_FRAME_BITS-1:1]};
    end
  end

  // serial pin: fault first, then one bit per falling edge
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      serialOut   <= 1'h0;
      serialOutEn <= 1'h0;
    end else begin
      serialOutEn <= !pin.chip_select_low;
      if (pin.chip_select_low) begin
        serialOut <= 1'h0;
      end else if (!started) begin
        serialOut <= fault;
      end else if (sclkFall) begin
        serialOut <= outShift[1];
      end
    end
  end

  // frames queue here; a wake-up settle time stalls the drain
  acd_fifo #(
    .W (`ACD_FRAME_BITS),
    .D (`ACD_FIFO_DEPTH)
  ) u_fifo (
    .clk      (clk),
    .rstn     (rstn),
    .inValid  (commit),
    .inReady  (fifoInRdy),
    .inData   (inShift),
    .outValid (fifoOutValid),
    .outReady (!notReady),
    .outData  (fifoData)
  );
  assign apply   = fifoOutValid && !notReady;
  assign w0      = acd_ctl0_s'(fifoData);
  assign stbyClr = apply && !w0.sel && !w0.en;
  assign clrAll  = (commit && fifoInRdy && inShift[`ACD_BIT_CLR])
                   || stbyClr;

  // a full queue refuses the frame and says so for one cycle
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      frameLost <= 1'h0;
    end else begin
      frameLost <= commit && !fifoInRdy;
    end
  end

  // input registers; standby wipes both
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      reg0 <= '0;
      reg1 <= '0;
    end else if (apply) begin
      if (w0.sel) begin
        reg1 <= acd_ctl1_s'(fifoData);
      end else if (w0.en) begin
        reg0 <= w0;
      end else begin
        reg0 <= '0;
        reg1 <= '0;
      end
    end
  end

  // charge pump settle timer after leaving standby
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      wakeCnt <= '0;
    end else if (apply && !w0.sel && w0.en && !reg0.en) begin
      wakeCnt <= `ACD_WAKE_W'(`ACD_WAKE_CYC);
    end else if (notReady) begin
      wakeCnt <= wakeCnt - 1'h1;
    end
  end

  // latched diagnostics; a live indication beats a clear
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      flg <= '0;
    end else begin
      flg <= acd_diag_s'(pin.d | (clrAll ? '0 : flg));
    end
  end

  // global switch-off terms
  assign supOff    = reg0.supRecDis ? (flg.ov || flg.uv)
                                    : (pin.d.ov || pin.d.uv);
  assign globalOff = !reg0.en || notReady || flg.thermal_shutdown_flag || supOff;
  assign pwmV      = {reg1.pwmEn, 1'h0};
  assign recV      = {reg1.recov, 1'h0};

  // per channel: gating, over-current, recovery, open load
  for (genvar ch = 1; ch <= `ACD_NCH; ch++) begin : g_ch
    localparam int O = (ch <= 2 * `ACD_NHB) ? (ch + 1) / 2
                     : (ch <= `ACD_HS_LAST) ? ch - `ACD_NHB : 0;
    logic                  gate;
    logic                  trip;
    logic                  ocOff;
    logic                  ocF;
    logic                  olF;
    logic [`ACD_OC_W-1:0]  ocCnt;
    logic [`ACD_REC_W-1:0] recCnt;
    logic [`ACD_OL_W-1:0]  olCnt;

    assign gate = (O == `ACD_GATE2_OUT) ? pin.g2 : pin.g1;
    assign trip = pin.oc[ch]
                  && ocCnt == `ACD_OC_W'(`ACD_OC_FILT_CYC - 1);
    // a trip stops the driver on the same edge that sets the flag
    assign ocOff = trip || (recV[O] ? (recCnt != '0) : ocF);
    assign dem[ch] = reg0.ctrl[ch] && (!pwmV[O] || gate)
                     && !ocOff && !globalOff;
    assign ocFlag[ch] = ocF;
    assign olFlag[ch] = olF;

    // over-current filter restarts on any gap in the indication
    always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
        ocCnt <= '0;
        ocF   <= 1'h0;
      end else begin
        ocCnt <= (pin.oc[ch] && !trip) ? ocCnt + 1'h1 : '0;
        ocF   <= trip || (ocF && !clrAll);
      end
    end

    // soft start off time; the filter time forms the on phase
    always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
        recCnt <= '0;
      end else if (trip && recV[O]) begin
        recCnt <= reg0.dutyHi ? `ACD_REC_W'(REC_OFF_HI)
                              : `ACD_REC_W'(REC_OFF_LO);
      end else if (recCnt != '0) begin
        recCnt <= recCnt - 1'h1;
      end
    end

    // open load only counts while the channel is driven
    always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
        olCnt <= '0;
        olF   <= 1'h0;
      end else begin
        olCnt <= (drvOn[ch] && pin.lc[ch]) ? olCnt + 1'h1 : '0;
        if (drvOn[ch] && pin.lc[ch]
            && olCnt == `ACD_OL_W'(OL_FILT_CYC - 1)) begin
          olF   <= 1'h1;
          olCnt <= '0;
        end else if (clrAll) begin
          olF <= 1'h0;
        end
      end
    end

    // half-bridge switches wait for the partner; others follow demand
    if (ch <= 2 * `ACD_NHB) begin : g_hb
      localparam int P = (ch % 2 == 1) ? ch + 1 : ch - 1;
      assign next_drv[ch] = dem[ch] && (drvOn[ch]
                            || (xCnt[O] == '0 && !drvOn[P] && !dem[P]));
    end else begin : g_hs
      assign next_drv[ch] = dem[ch];
    end

    property p_oc_trip;
      trip |=> ocF && !drvOn[ch];
    endproperty
    a_oc_trip: assert property (p_oc_trip)
      else $error("over-current trip did not latch or stop driver");

    property p_oc_hold;
      (ocF && !recV[O] && !clrAll) |=> !drvOn[ch];
    endproperty
    a_oc_hold: assert property (p_oc_hold)
      else $error("driver came back without a flag clear");
  end

  // cross-current delay starts whenever a bridge switch turns off
  for (genvar k = 1; k <= `ACD_NHB; k++) begin : g_x
    always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
        xCnt[k] <= '0;
      end else if ((drvOn[2*k-1] && !next_drv[2*k-1])
                   || (drvOn[2*k] && !next_drv[2*k])) begin
        xCnt[k] <= `ACD_X_W'(`ACD_XDLY_CYC);
      end else if (xCnt[k] != '0) begin
        xCnt[k] <= xCnt[k] - 1'h1;
      end
    end
  end

  // driver, pump and monitor outputs
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      drvOn        <= '0;
      chargePumpOn <= 1'h0;
      monitorSel   <= '0;
    end else begin
      drvOn        <= next_drv;
      chargePumpOn <= reg0.en;
      monitorSel   <= reg0.monSel;
    end
  end

  property p_float;
    pin.chip_select_low |=> !serialOutEn;
  endproperty
  a_float: assert property (p_float)
    else $error("serial output driven with chip select high");

  property p_poll;
    $fell(pin.chip_select_low) |=> serialOutEn && serialOut == $past(fault);
  endproperty
  a_poll: assert property (p_poll)
    else $error("fault bit not shown after chip select fell");

  property p_out_edge;
    ($past(started) && !$past(pin.chip_select_low) && !pin.chip_select_low
     && serialOut != $past(serialOut)) |-> $past(sclkFall);
  endproperty
  a_out_edge: assert property (p_out_edge)
    else $error("serial output moved off a falling edge");

  property p_commit;
    (commit && !fifoOutValid && !notReady && !inShift[`ACD_BIT_SEL]
     && inShift[`ACD_BIT_EN]) |-> ##2 reg0 == $past(inShift, 2);
  endproperty
  a_commit: assert property (p_commit)
    else $error("valid frame not written two cycles after close");

  property p_drop;
    (csnRise && bitCnt != `ACD_CNT_W'(`ACD_FRAME_BITS) && !fifoOutValid)
      |=> $stable(reg0) && $stable(reg1);
  endproperty
  a_drop: assert property (p_drop)
    else $error("bad-length frame changed an input register");

  property p_clear;
    (commit && fifoInRdy && inShift[`ACD_BIT_CLR])
      |=> flg.tw == $past(pin.d.tw) && olFlag == '0;
  endproperty
  a_clear: assert property (p_clear)
    else $error("status clear did not act at frame close");

  property p_tsd;
    flg.thermal_shutdown_flag |=> drvOn == '0;
  endproperty
  a_tsd: assert property (p_tsd)
    else $error("driver on during thermal shutdown");

  property p_stby;
    !reg0.en |=> !chargePumpOn && drvOn == '0;
  endproperty
  a_stby: assert property (p_stby)
    else $error("pump or driver on in standby");

  c_commit: cover property (commit && fifoInRdy);
  c_discard: cover property (csnRise && !commit);
  c_full: cover property (commit && !fifoInRdy);
  c_trip: cover property (g_ch[1].trip);
endmodule // acd_spi_ctrl

`default_nettype wire

// ==== rtl/acd_defines.svh ====
// constants for the actuator serial control and diagnostic block
`ifndef ACD_DEFINES_SVH
`define ACD_DEFINES_SVH
`define ACD_CLK_MHZ      40
`define ACD_FRAME_BITS   24
`define ACD_CNT_W        5
`define ACD_BIT_SEL      0
`define ACD_BIT_CLR      22
`define ACD_BIT_EN       23
`define ACD_NCH          17
`define ACD_NOUT         8
`define ACD_NHB          5
`define ACD_HS_LAST      13
`define ACD_GATE2_OUT    7
`define ACD_FIFO_DEPTH   4
`define ACD_OC_FILT_US   32
`define ACD_OC_FILT_CYC  (`ACD_OC_FILT_US * `ACD_CLK_MHZ)
`define ACD_OC_W         11
`define ACD_OL_FILT_US   1000
`define ACD_OL_FILT_CYC  (`ACD_OL_FILT_US * `ACD_CLK_MHZ)
`define ACD_OL_W         16
`define ACD_WAKE_US      20
`define ACD_WAKE_CYC     (`ACD_WAKE_US * `ACD_CLK_MHZ)
`define ACD_WAKE_W       10
`define ACD_XDLY_NS      1000
`define ACD_XDLY_CYC     (`ACD_XDLY_NS * `ACD_CLK_MHZ / 1000)
`define ACD_X_W          6
`define ACD_REC_HZ       3000
`define ACD_REC_CYC      (`ACD_CLK_MHZ * 1000000 / `ACD_REC_HZ)
`define ACD_DUTY_LO      12
`define ACD_DUTY_HI      25
`define ACD_REC_OFF(d)   (`ACD_REC_CYC * (100 - (d)) / 100)
`define ACD_REC_W        14
`endif

// ==== rtl/acd_pkg.sv ====
// types shared by the actuator serial control block
`default_nettype none
package acd_pkg;
  typedef logic [23:0] acd_word_t;
  typedef struct packed {
    logic        en;
    logic        statClr;
    logic        dutyHi;
    logic        supRecDis;
    logic [1:0]  monSel;
    logic [17:1] ctrl;
    logic        sel;
  } acd_ctl0_s;
  typedef struct packed {
    logic [6:0] rsv;
    logic [8:1] recov;
    logic [8:1] pwmEn;
    logic       sel;
  } acd_ctl1_s;
  typedef struct packed {
    logic ov;
    logic uv;
    logic thermal_shutdown_flag;
    logic tw;
  } acd_diag_s;
  typedef struct packed {
    logic        sclk;
    logic        chip_select_low;
    logic        sdi;
    logic        g1;
    logic        g2;
    acd_diag_s   d;
    logic [17:1] oc;
    logic [17:1] lc;
  } acd_pins_s;
endpackage
`default_nettype wire

// ==== testbench/acd_spi_master.sv ====
// serial master model driving the actuator control link
`default_nettype none
module acd_spi_master (
  output logic      spiClk,
  output logic      chipSelectLow,
  output logic      serialIn,
  input  wire logic serialData
);
  timeunit 1ns;
  timeprecision 100ps;

  // idle link: clock low, chip select high
  initial begin
    spiClk        = 1'b0;
    chipSelectLow = 1'b1;
    serialIn      = 1'b0;
  end

  // one frame of n clocks; rx[0] also holds the polled fault bit
  task automatic xfer(input int n, input logic [23:0] tx,
                      output logic [23:0] rx);
    int i;
    rx = 24'h000000;
    #7 chipSelectLow = 1'b0;
    serialIn = tx[0];
    // fault bit needs a few system clocks after select
    #193 rx[0] = serialData;
    for (i = 0; i < n; i++) begin
      spiClk = 1'b1;
      rx[i % 24] = serialData;
      #100 spiClk = 1'b0;
      serialIn = tx[(i + 1) % 24];
      #100;
    end
    chipSelectLow = 1'b1;
    // released line must not keep its last value
    serialIn = ~serialIn;
    #200;
  endtask
endmodule // acd_spi_master
`default_nettype wire

// ==== testbench/actuator_spi_control_diag_bench.sv ====
// self-checking bench for the actuator serial control block
`default_nettype none
module actuator_spi_control_diag_bench;
  timeunit 1ns;
  timeprecision 100ps;
  import acd_pkg::*;

  logic        clk;
  logic        rstn;
  logic        g1;
  logic        g2;
  acd_diag_s   diag;
  logic [17:1] oc;
  logic [17:1] lc;
  logic        spiClk;
  logic        csLow;
  logic        sdi;
  logic        sdo;
  logic        sdoEn;
  wire         sdoWire;
  logic [17:1] drvOn;
  logic        cpOn;
  logic [1:0]  monSel;
  logic        frameLost;
  logic [23:0] cur0;
  logic [23:0] cur1;
  logic [23:0] rx;
  logic [18:0] rnd;
  logic [17:1] expD;
  int          lostCnt = 0;
  int          num_errors;
  int          num_checks;
  int          seed;
  int          i;

  // data pin floats while the block does not drive it
  assign sdoWire = sdoEn ? sdo : 1'bz;

  acd_spi_ctrl #(
    .OL_FILT_CYC(40),
    .REC_OFF_LO (20),
    .REC_OFF_HI (10)
  ) u_acd_spi_ctrl (
    .clk                  (clk),
    .rstn                 (rstn),
    .spiClk               (spiClk),
    .chipSelectLow        (csLow),
    .serialIn             (sdi),
    .serialOut            (sdo),
    .serialOutEn          (sdoEn),
    .pulseGateInputOne    (g1),
    .monitorOrPulseGatePin(g2),
    .diagInd              (diag),
    .overCurInd           (oc),
    .lowCurInd            (lc),
    .drvOn                (drvOn),
    .chargePumpOn         (cpOn),
    .monitorSel           (monSel),
    .frameLost            (frameLost)
  );

  acd_spi_master u_acd_spi_master (
    .spiClk       (spiClk),
    .chipSelectLow(csLow),
    .serialIn     (sdi),
    .serialData   (sdoWire)
  );

  // 40 MHz system clock
  initial clk = 1'b0;
  always #12.5 clk = ~clk;

  // refused frames would show here; none is expected in this run
  always @(posedge clk) begin
    if (frameLost !== 1'b0) begin
      lostCnt <= lostCnt + 1;
    end
  end

  // a bridge demanded both ways keeps only the switch already on
  function automatic logic [17:1] expDrv(logic [17:1] c, logic [17:1] prev);
    int k;
    expDrv = c;
    for (k = 1; k <= 5; k++) begin
      if (c[2*k-1] && c[2*k]) begin
        expDrv[2*k-1] = prev[2*k-1];
        expDrv[2*k]   = prev[2*k];
      end
    end
  endfunction

  // status word: top bit set, flags, summary fault over both registers
  function automatic logic [23:0] expStat(logic [22:1] f, logic other);
    expStat = {1'b1, f, (|f) | other};
  endfunction

  task automatic wclk(int n);
    repeat (n) @(negedge clk);
  endtask

  task automatic cmp(logic [23:0] got, logic [23:0] exp);
    num_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic cmpb(logic got, logic exp);
    cmp({23'h000000, got}, {23'h000000, exp});
  endtask

  task automatic cmpDrv(logic [17:1] exp);
    cmp({7'h00, drvOn}, {7'h00, exp});
  endtask

  // full frame, then margin for the queue to commit
  task automatic frame(logic [23:0] w);
    u_acd_spi_master.xfer(24, w, rx);
    wclk(8);
  endtask

  task automatic test_done;
    if (num_errors == 0 && num_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // hang guard, far beyond the expected run length
  initial begin
    #1000000;
    num_errors++;
    test_done();
  end

  initial begin
    seed       = 32'h14A6;
    num_errors = 0;
    num_checks = 0;
    rstn       = 1'b0;
    g1         = 1'b0;
    g2         = 1'b0;
    diag       = '0;
    oc         = '0;
    lc         = '0;
    cur1       = 24'h000001;
    wclk(20);
    rstn = 1'b1;
    cmpDrv(17'h00000);
    cmpb(cpOn, 1'b0);
    cmpb(sdoEn, 1'b0);
    wclk(4);
    // wake from standby: settle time shows as fault
    cur0 = {4'h8, 2'b10, 17'h00000, 1'b0};
    frame(cur0);
    cmpb(cpOn, 1'b1);
    cmp({22'h0, monSel}, {22'h0, 2'b10});
    u_acd_spi_master.xfer(0, cur0, rx);
    cmpb(rx[0], 1'b1);
    wclk(900);
    u_acd_spi_master.xfer(0, cur0, rx);
    cmpb(rx[0], 1'b0);
    frame(cur0);
    cmp(rx, expStat(22'h0, 1'b0));
    // corner patterns first, then random ones
    expD = '0;
    for (i = 0; i < 8; i++) begin
      rnd = (i == 0) ? 19'h7FFFF : (i == 1) ? 19'h15555 :
            (i == 2) ? 19'h2AAAA : 19'($random(seed));
      cur0 = {4'h8, rnd[18:17], rnd[16:0], 1'b0};
      frame(cur0);
      wclk(60);
      expD = expDrv(rnd[16:0], expD);
      cmpDrv(expD);
      cmp({22'h0, monSel}, {22'h0, rnd[18:17]});
    end
    // swap high to low switch of bridge one
    cur0 = {4'h8, 2'b00, 17'h00001, 1'b0};
    frame(cur0);
    wclk(60);
    cur0 = {4'h8, 2'b00, 17'h00002, 1'b0};
    frame(cur0);
    cmpDrv(17'h00000);
    wclk(50);
    cmpDrv(17'h00002);
    // low current on one enabled and one disabled channel
    cur0 = {4'h8, 2'b00, 17'h00400, 1'b0};
    frame(cur0);
    lc[11] = 1'b1;
    lc[13] = 1'b1;
    wclk(60);
    frame(cur1);
    cmp(rx, expStat(22'h000400, 1'b0));
    frame(cur0);
    cmp(rx, expStat(22'h0, 1'b1));
    lc = '0;
    // wrong counts must neither write nor clear
    u_acd_spi_master.xfer(23, 24'h400000, rx);
    u_acd_spi_master.xfer(25, 24'h400000, rx);
    wclk(8);
    cmpb(cpOn, 1'b1);
    cmpb(sdoEn, 1'b0);
    frame(cur1);
    cmp(rx, expStat(22'h000400, 1'b0));
    frame(cur0 | 24'h400000);
    frame(cur1);
    cmp(rx, expStat(22'h0, 1'b0));
    // over-current just short of and past the filter time
    oc[11] = 1'b1;
    wclk(1200);
    cmpDrv(17'h00400);
    wclk(100);
    cmpDrv(17'h00000);
    oc[11] = 1'b0;
    wclk(50);
    cmpDrv(17'h00000);
    frame(cur0);
    cmp(rx, expStat(22'h000400, 1'b0));
    frame(cur0 | 24'h400000);
    wclk(10);
    cmpDrv(17'h00400);
    // shutdown latches; clear fails while warning still shown
    diag.thermal_shutdown_flag = 1'b1;
    diag.tw  = 1'b1;
    wclk(10);
    cmpDrv(17'h00000);
    diag.thermal_shutdown_flag = 1'b0;
    wclk(10);
    cmpDrv(17'h00000);
    frame(cur0);
    cmp(rx, expStat(22'h0C0000, 1'b0));
    frame(cur0 | 24'h400000);
    frame(cur0);
    cmp(rx, expStat(22'h040000, 1'b0));
    cmpDrv(17'h00400);
    // gating of outputs six and seven by the two gate inputs
    cur1 = 24'h0000C1;
    frame(cur1);
    cur0 = {4'h8, 2'b00, 17'h00C00, 1'b0};
    frame(cur0);
    for (i = 0; i < 4; i++) begin
      g1 = i[0];
      g2 = i[1];
      wclk(10);
      cmpDrv({5'h00, g2, g1, 10'h000});
    end
    // standby drops everything
    cur0 = 24'h000000;
    frame(cur0);
    cmpb(cpOn, 1'b0);
    cmpDrv(17'h00000);
    cmp(24'(lostCnt), 24'h000000);
    test_done();
  end
endmodule // actuator_spi_control_diag_bench
`default_nettype wire
